// [shared/pucr_pkg.sv]
// Constants shared by the profiling capability report block.
package pucr_pkg;
	// Capability query leaves selected on i_query_leaf.
	localparam logic [1:0] LEAF_EXT_FEATURE = 2'h0; // Extended feature word.
	localparam logic [1:0] LEAF_HW_CAPS = 2'h1; // profiling_hw_capabilities.
	localparam logic [1:0] LEAF_APP_CAPS = 2'h2; // Application-visible word.
	localparam logic [1:0] LEAF_SIZES = 2'h3; // Sizes and counter width.
	// Bit positions in the capability words.
	localparam int BIT_SUPPORTED = 0; // profiler_supported.
	localparam int BIT_EVT_FIRST = 1; // value_sample_supported.
	localparam int BIT_EVT_LAST = 6; // ref_clk_unhalted_supported.
	localparam int BIT_CONTINUOUS = 29; // continuous_sampling_supported.
	localparam int BIT_TIMESTAMP = 30; // timestamp_in_record_supported.
	localparam int BIT_THRESH_IRQ = 31; // threshold_irq_supported.
	localparam int BIT_EXT_PRESENT = 15; // Profiler flag in feature word.
	localparam int BIT_EXT_STATE = 26; // Save/restore flag, feature word.
	localparam int BIT_XCR_PROFILER = 62; // Enable bit in the feature mask.
	// Sizes word layout.
	localparam int SZ_LAT_LSB = 0; // latency_counter_max, 5 bits.
	localparam int SZ_REC_LSB = 8; // record_size_bytes, 8 bits.
	localparam int SZ_MIN_LSB = 16; // min_ring_size, 16 bits.
	localparam int LAT_MIN = 10; // Smallest legal latency width.
	localparam int LAT_MAX = 31; // Largest legal latency width.
	localparam int RING_UNIT = 32; // min_ring_size counts this many records.
	// Hardware capabilities of this core, fixed at design time.
	localparam logic [31:0] HW_FEATURES = 32'he000_007f; // All features.
	localparam logic [4:0] HW_LAT_WIDTH = 5'h10; // Latency counter bits.
	localparam logic [7:0] HW_REC_SIZE = 8'h20; // Bytes per event record.
	localparam logic [15:0] HW_MIN_RING = 16'h0001; // Units of RING_UNIT.
	// Model-specific register selects and field layout.
	localparam logic MSR_SEL_CFG = 1'b0; // profiler_config.
	localparam logic MSR_SEL_CBADDR = 1'b1; // control_block_address.
	localparam int CFG_WIDTH = 48; // Implemented config bits.
	localparam logic [63:0] CFG_RESET = 64'h0; // Config after reset.
	localparam logic [63:0] CBADDR_RESET = 64'h0; // Block address after reset.
endpackage : pucr_pkg

// [verilog/pucr_cap_word.sv]
// Builds a constant capability word with reserved bits forced to zero.
`timescale 1ns/1ns
module pucr_cap_word (
	input wire logic i_present, // Profiler present in this core.
	input wire logic [31:0] i_features, // Feature bits before masking.
	output logic [31:0] o_word // Finished capability word.
);
	import pucr_pkg::*;
	//////////////////////////////////////////////////////////////////////
	// One bit per position: bit 0 is the present flag, the event range and the three
	// option bits pass only when the core has the profiler, everything else is zero.
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_bit
			if (g == BIT_SUPPORTED) begin : g_sup
				assign o_word[g] = i_present;
			end else if ((g >= BIT_EVT_FIRST && g <= BIT_EVT_LAST) ||
				g == BIT_CONTINUOUS || g == BIT_TIMESTAMP ||
				g == BIT_THRESH_IRQ) begin : g_feat
				// Feature bits mean nothing without the profiler.
				assign o_word[g] = i_present & i_features[g];
			end else begin : g_rsv
				assign o_word[g] = 1'b0;
			end
		end
	endgenerate
endmodule : pucr_cap_word

// [verilog/pucr_top.sv]
// Capability report, enable gating and block address of the profiler.
// How it works
// - Bit 0 reports profiler support.
// - Bit 0 equals feature word bit 15.
// - Bits 1-6 report the six event kinds.
// - Bit 29 reports continuous sampling.
// - Bit 30 reports timestamps in records.
// - Bit 31 reports threshold interrupt.
// - Latency counter width between 10 and 31.
// - Minimum ring size in 32-record units.
// - Profiler registers need feature bit 15.
// - Usable only when enable mask bit set.
// - Enabling mask bit starts profiler disabled.
// - Save/restore support reported with profiler.
// - Application bits are config subset.
// - Zero block address disables, drops state.
`timescale 1ns/1ns
module pucr_top #(
	parameter bit PROFILER_PRESENT = 1'b1 // Core carries the profiler.
) (
	input wire logic i_clk_sys, // System clock, 10 MHz.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire logic i_query_req, // Capability query pulse.
	input wire logic [1:0] i_query_leaf, // Which word to return.
	output logic o_query_ack, // Query answer pulse.
	output logic [31:0] o_query_data, // Query answer word.
	input wire logic i_xcr_wr, // Feature mask write pulse.
	input wire logic [63:0] i_xcr_wdata, // Feature mask write value.
	input wire logic i_msr_wr, // Profiler register write pulse.
	input wire logic i_msr_rd, // Profiler register read pulse.
	input wire logic i_msr_sel, // Register select.
	input wire logic [63:0] i_msr_wdata, // Register write value.
	output logic o_msr_ack, // Register access done, pulse.
	output logic o_msr_fault, // Access refused, pulse with ack.
	output logic [63:0] o_msr_rdata, // Register read value.
	input wire logic i_cb_load, // Validated block address load pulse.
	input wire logic [63:0] i_cb_addr, // Address to load, zero disables.
	output logic o_profiler_usable, // Present and enabled by the OS.
	output logic o_profiler_active, // Block address is nonzero.
	output logic [63:0] o_cb_addr // Current control block address.
);
	import pucr_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// Constant capability words.
	logic [31:0] hw_caps; // Full hardware capability word.
	logic [31:0] ext_word; // Extended feature word.
	logic [31:0] size_word; // Sizes and latency width.
	logic [4:0] lat_width; // Latency width held inside its range.

	// The word is built from constants only, so software cannot alter it.
	pucr_cap_word u_caps (
		.i_present(PROFILER_PRESENT),
		.i_features(HW_FEATURES),
		.o_word(hw_caps)
	);

	// Clamp guards against a bad constant edit escaping the legal range.
	assign lat_width = (HW_LAT_WIDTH < 5'(LAT_MIN)) ? 5'(LAT_MIN) :
		HW_LAT_WIDTH;
	assign size_word = (32'(lat_width) << SZ_LAT_LSB) |
		(32'(HW_REC_SIZE) << SZ_REC_LSB) |
		(32'(HW_MIN_RING) << SZ_MIN_LSB);
	// Save/restore is reported alongside the profiler flag.
	assign ext_word = (32'(PROFILER_PRESENT) << BIT_EXT_PRESENT) |
		(32'(PROFILER_PRESENT) << BIT_EXT_STATE);

	//////////////////////////////////////////////////////////////////////
	// Operating system state.
	logic xcr_enable; // Feature mask bit for the profiler.
	logic [63:0] cfg; // profiler_config contents.
	logic [63:0] cb_addr; // control_block_address contents.
	logic next_xcr_enable; // Next feature mask bit.
	logic [63:0] next_cfg; // Next config.
	logic [63:0] next_cb_addr; // Next block address.
	logic usable; // Profiler may be used by applications.
	logic msr_access; // Any register access this cycle.
	logic msr_ok; // Access allowed by the present flag.
	logic cfg_bad; // Write sets bits the hardware lacks.
	logic cfg_wr_ok; // Accepted config write.
	logic cb_wr_bad; // Nonzero write to the block address.
	logic cb_wr_zero; // Zero write to the block address.
	logic xcr_rise; // Mask bit going from 0 to 1.
	logic msr_fault; // Refused register access.
	logic [31:0] app_caps; // Application-visible word.
	logic [63:0] cfg_allowed; // Config bits software may set.
	logic [31:0] leaf_data; // Selected query word.
	logic [63:0] msr_data; // Selected register read word.

	// Mask bit is only kept when the core has a profiler at all.
	assign next_xcr_enable = i_xcr_wr ?
		(i_xcr_wdata[BIT_XCR_PROFILER] & PROFILER_PRESENT) :
		xcr_enable;
	assign xcr_rise = next_xcr_enable & ~xcr_enable;
	assign usable = PROFILER_PRESENT & xcr_enable;

	assign msr_access = i_msr_wr | i_msr_rd;
	assign msr_ok = PROFILER_PRESENT;
	// Feature bits follow the hardware word, core id and vector are free.
	assign cfg_allowed = {16'h0, 16'hffff, hw_caps[31:1], 1'b0};
	assign cfg_bad = |(i_msr_wdata & ~cfg_allowed);
	assign cfg_wr_ok = i_msr_wr & msr_ok & (i_msr_sel == MSR_SEL_CFG) &
		~cfg_bad;
	assign cb_wr_zero = i_msr_wr & msr_ok & (i_msr_sel == MSR_SEL_CBADDR) &
		(i_msr_wdata == 64'h0);
	// Only the load path may install a nonzero address.
	assign cb_wr_bad = i_msr_wr & (i_msr_sel == MSR_SEL_CBADDR) &
		(i_msr_wdata != 64'h0);
	assign msr_fault = msr_access & (~msr_ok | (i_msr_wr &
		(((i_msr_sel == MSR_SEL_CFG) & cfg_bad) | cb_wr_bad)));

	assign next_cfg = cfg_wr_ok ? i_msr_wdata : cfg;
	// Zero write wins over a load in the same cycle: it is the OS stop.
	assign next_cb_addr = (cb_wr_zero | xcr_rise | ~usable) ? 64'h0 :
		(i_cb_load ? i_cb_addr : cb_addr);

	// Application word mirrors config masked by hardware, with the OS usable bit in bit 0.
	assign app_caps = {cfg[31:1] & hw_caps[31:1], usable};

	assign leaf_data = (i_query_leaf == LEAF_EXT_FEATURE) ? ext_word :
		(i_query_leaf == LEAF_HW_CAPS) ? hw_caps :
		(i_query_leaf == LEAF_APP_CAPS) ? app_caps : size_word;
	assign msr_data = (~msr_ok | ~i_msr_rd) ? 64'h0 :
		(i_msr_sel == MSR_SEL_CFG) ? cfg : cb_addr;

	//////////////////////////////////////////////////////////////////////
	// State registers.
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			xcr_enable <= 1'b0;
			cfg <= CFG_RESET;
			cb_addr <= CBADDR_RESET;
		end else begin
			xcr_enable <= next_xcr_enable;
			cfg <= next_cfg;
			cb_addr <= next_cb_addr;
		end
	end

	// Answer registers: every output leaves straight from a flip-flop.
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_query_ack <= 1'b0;
			o_query_data <= 32'h0;
			o_msr_ack <= 1'b0;
			o_msr_fault <= 1'b0;
			o_msr_rdata <= 64'h0;
		end else begin
			o_query_ack <= i_query_req;
			o_query_data <= i_query_req ? leaf_data : o_query_data;
			o_msr_ack <= msr_access;
			o_msr_fault <= msr_fault;
			o_msr_rdata <= msr_access ? msr_data : o_msr_rdata;
		end
	end

	// Status outputs register the next state: address and active match cb_addr; usable needs the mask bit this cycle and last.
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_profiler_usable <= 1'b0;
			o_profiler_active <= 1'b0;
			o_cb_addr <= 64'h0;
		end else begin
			o_profiler_usable <= usable & ~xcr_rise &
				next_xcr_enable;
			o_profiler_active <= next_cb_addr != 64'h0;
			o_cb_addr <= next_cb_addr;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_hw_query;
		i_query_req && i_query_leaf == LEAF_HW_CAPS;
	endsequence
	sequence s_zero_write;
		i_msr_wr && i_msr_sel == MSR_SEL_CBADDR && i_msr_wdata == 64'h0;
	endsequence

	a_support_bit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_hw_query |=> o_query_data[BIT_SUPPORTED] ==
		ext_word[BIT_EXT_PRESENT])
		else $error("Support bit differs from feature word.");
	a_reserved_zero: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		s_hw_query |=> o_query_data[28:7] == 22'h0)
		else $error("Reserved capability bits not zero.");
	a_caps_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_hw_query ##1 !o_query_data[BIT_SUPPORTED] |->
		o_query_data == 32'h0)
		else $error("Features reported without profiler.");
	a_latency_range: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		i_query_req && i_query_leaf == LEAF_SIZES |=>
		o_query_data[4:0] >= 5'(LAT_MIN) &&
		o_query_data[4:0] <= 5'(LAT_MAX))
		else $error("Latency width out of range.");
	a_app_subset: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_query_req && i_query_leaf == LEAF_APP_CAPS |=>
		(o_query_data[31:1] & ~hw_caps[31:1]) == 31'h0 &&
		o_query_data[0] == $past(usable))
		else $error("Application word not a subset.");
	a_zero_stops: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_zero_write ##0 msr_ok |=> !o_profiler_active && cb_addr == 64'h0
		##1 (cb_addr == 64'h0 || $past(i_cb_load)))
		else $error("Zero write did not stop profiling.");
	a_enable_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		xcr_rise |=> cb_addr == 64'h0 && !o_profiler_active)
		else $error("Profiler not disabled on enable.");
	a_msr_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		msr_access && !msr_ok |=> o_msr_ack && o_msr_fault &&
		o_msr_rdata == 64'h0)
		else $error("Register reached without profiler.");
	a_usable_gate: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		!xcr_enable [*2] |-> !o_profiler_usable)
		else $error("Usable without the mask bit.");
	a_cfg_reject: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_msr_wr && i_msr_sel == MSR_SEL_CFG && cfg_bad |=>
		o_msr_fault && $stable(cfg))
		else $error("Unsupported config bit accepted.");

	//////////////////////////////////////////////////////////////////////
	// Further checks on answer timing, the constant words and the address.
	// Each one watches flip-flops or internal state, so a failure points
	// at the design and never at whoever drives the inputs.
	sequence s_ext_query;
		i_query_req && i_query_leaf == LEAF_EXT_FEATURE;
	endsequence
	sequence s_size_query;
		i_query_req && i_query_leaf == LEAF_SIZES;
	endsequence
	sequence s_cb_nonzero_write;
		i_msr_wr && i_msr_sel == MSR_SEL_CBADDR && i_msr_wdata != 64'h0;
	endsequence
	sequence s_good_load;
		i_cb_load && usable && !xcr_rise;
	endsequence

	// Every query is answered on the very next edge, never later.
	a_query_answer: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		i_query_req |=> o_query_ack)
		else $error("Query not answered.");

	// A stray ack would make software read a stale word as fresh.
	a_query_quiet: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		!i_query_req |=> !o_query_ack)
		else $error("Query ack without a request.");

	// The full word equals the fixed feature set, or zero without one.
	a_hw_word: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_hw_query |=> o_query_data ==
		(PROFILER_PRESENT ? HW_FEATURES : 32'h0))
		else $error("Capability word differs from the feature set.");

	// Save/restore must be reported whenever the profiler is.
	a_ext_flags: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_ext_query |=> o_query_data[BIT_EXT_PRESENT] == PROFILER_PRESENT &&
		o_query_data[BIT_EXT_STATE] == PROFILER_PRESENT)
		else $error("Feature word flags wrong.");

	// The minimum ring size leaves in its own field, untouched.
	a_ring_size: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_size_query |=> o_query_data[31:16] == HW_MIN_RING)
		else $error("Minimum ring size field wrong.");

	// Only the load path may install a nonzero address; a nonzero write must fault.
	a_cb_refuse: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_cb_nonzero_write |=> o_msr_fault)
		else $error("Nonzero address write not refused.");

	// Every register access gets its ack one cycle later.
	a_msr_answer: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		msr_access |=> o_msr_ack)
		else $error("Register access not answered.");

	// A load while usable, with no stop in the same cycle, is taken.
	a_load_taken: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_good_load ##0 !cb_wr_zero |=>
		cb_addr == $past(i_cb_addr))
		else $error("Valid address load lost.");

	// Without the mask bit no address may survive into the next cycle.
	a_unusable_clear: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		!usable |=> cb_addr == 64'h0)
		else $error("Address kept while unusable.");

	// The active flag is exactly the nonzero test of the address.
	a_active_level: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		o_profiler_active == (cb_addr != 64'h0))
		else $error("Active flag disagrees with address.");

	// The address output is a registered copy of the internal address.
	a_addr_mirror: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		o_cb_addr == cb_addr)
		else $error("Address output disagrees with state.");

	// The hardware word never moves while the core runs.
	a_caps_steady: assert property (@(posedge i_clk_sys)
		disable iff (i_reset)
		$stable(hw_caps))
		else $error("Capability word changed.");
endmodule : pucr_top

// [sim/pucr_top_tb.sv]
// Self-checking testbench for the profiling capability report block.
`timescale 1ns/1ns
module pucr_top_tb;
	import pucr_pkg::*;
	logic i_clk_sys, i_reset, i_query_req, i_xcr_wr, i_msr_wr, i_msr_rd;
	logic i_msr_sel, i_cb_load, o_query_ack, o_msr_ack, o_msr_fault;
	logic o_profiler_usable, o_profiler_active;
	logic [1:0] i_query_leaf;
	logic [31:0] o_query_data;
	logic [63:0] i_xcr_wdata, i_msr_wdata, o_msr_rdata, i_cb_addr, o_cb_addr;
	int miscompares = 0; // Mismatches seen so far.
	int check_count = 0; // Comparisons made so far.
	int cycles = 0; // Cycle count for the hang guard.
	logic [63:0] m_cfg, m_cb, addr, v; // Reference model state and scratch.
	logic m_usable; // Model of the OS enable bit.
	// Config bits that may be set: hardware features, core id, vector.
	localparam logic [63:0] CFG_OK = 64'h0000_ffff_e000_007e;
	pucr_top u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_query_req(i_query_req), .i_query_leaf(i_query_leaf),
		.o_query_ack(o_query_ack), .o_query_data(o_query_data),
		.i_xcr_wr(i_xcr_wr), .i_xcr_wdata(i_xcr_wdata), .i_msr_wr(i_msr_wr),
		.i_msr_rd(i_msr_rd), .i_msr_sel(i_msr_sel), .i_msr_wdata(i_msr_wdata),
		.o_msr_ack(o_msr_ack), .o_msr_fault(o_msr_fault),
		.o_msr_rdata(o_msr_rdata), .i_cb_load(i_cb_load), .i_cb_addr(i_cb_addr),
		.o_profiler_usable(o_profiler_usable),
		.o_profiler_active(o_profiler_active), .o_cb_addr(o_cb_addr));
	////////////////////////////////////////////////////////////////////////////
	// The clock toggles every half period of 50 ns.
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	// The hang guard; the whole run needs well under 200 cycles.
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares = miscompares + 1;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Compares one value seen at the ports with the model's expectation.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk
	// Prints the verdict and stops the run.
	task automatic end_sim();
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// One query pulse; the answer is read while the ack pulse stands.
	task automatic query(input logic [1:0] leaf);
		@(negedge i_clk_sys);
		i_query_req = 1'b1;
		i_query_leaf = leaf;
		@(negedge i_clk_sys);
		i_query_req = 1'b0;
		chk({63'h0, o_query_ack}, 64'h1);
	endtask : query
	// One register access; ack and fault are read in their single cycle.
	task automatic msr(input logic wr, input logic sel, input logic [63:0] d,
		input logic fault);
		@(negedge i_clk_sys);
		i_msr_wr = wr;
		i_msr_rd = ~wr;
		i_msr_sel = sel;
		i_msr_wdata = d;
		@(negedge i_clk_sys);
		i_msr_wr = 1'b0;
		i_msr_rd = 1'b0;
		chk({62'h0, o_msr_ack, o_msr_fault}, {62'h0, 1'b1, fault});
	endtask : msr
	// Writes the enable bit of the feature mask and lets it settle.
	task automatic set_mask(input logic en);
		@(negedge i_clk_sys);
		i_xcr_wr = 1'b1;
		i_xcr_wdata = {1'b0, en, 62'h0};
		@(negedge i_clk_sys);
		i_xcr_wr = 1'b0;
		@(negedge i_clk_sys);
		m_usable = en;
		if (!en) m_cb = 64'h0;
		chk({63'h0, o_profiler_usable}, {63'h0, m_usable});
	endtask : set_mask
	// Offers a block address; it is only taken while profiling is usable.
	task automatic load(input logic [63:0] a);
		@(negedge i_clk_sys);
		i_cb_load = 1'b1;
		i_cb_addr = a;
		@(negedge i_clk_sys);
		i_cb_load = 1'b0;
		if (m_usable) m_cb = a;
		chk(o_cb_addr, m_cb);
		chk({63'h0, o_profiler_active}, {63'h0, m_cb != 64'h0});
	endtask : load
	////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, capability words, registers, enable gating.
	initial begin
		{i_reset, i_query_req, i_xcr_wr, i_msr_wr, i_msr_rd} = 5'h10;
		{i_msr_sel, i_cb_load, i_query_leaf} = 4'h0;
		{i_xcr_wdata, i_msr_wdata, i_cb_addr} = '0;
		{m_cfg, m_cb, m_usable} = '0;
		void'($urandom(32775));
		repeat (6) @(negedge i_clk_sys);
		i_reset = 1'b0;
		chk(o_cb_addr, 64'h0);
		query(LEAF_HW_CAPS);
		chk({32'h0, o_query_data}, 64'he000_007f);
		query(LEAF_HW_CAPS);
		chk({32'h0, o_query_data}, 64'he000_007f);
		query(LEAF_EXT_FEATURE);
		chk({62'h0, o_query_data[15], o_query_data[26]}, 64'h3);
		query(LEAF_SIZES);
		chk({59'h0, o_query_data[4:0]}, {59'h0, HW_LAT_WIDTH});
		chk({63'h0, o_query_data[4:0] >= 5'ha}, 64'h1);
		chk({48'h0, o_query_data[31:16]}, {48'h0, HW_MIN_RING});
		chk({56'h0, o_query_data[15:8]}, {56'h0, HW_REC_SIZE});
		query(LEAF_APP_CAPS);
		chk({32'h0, o_query_data}, 64'h0);
		msr(1'b0, MSR_SEL_CBADDR, 64'h0, 1'b0);
		chk(o_msr_rdata, 64'h0);
		msr(1'b1, MSR_SEL_CBADDR, 64'h40, 1'b1);
		msr(1'b1, MSR_SEL_CFG, 64'h1_0000_0000_0000, 1'b1);
		msr(1'b1, MSR_SEL_CFG, 64'h80, 1'b1);
		v = {$urandom, $urandom} & CFG_OK;
		msr(1'b1, MSR_SEL_CFG, v, 1'b0);
		m_cfg = v;
		msr(1'b0, MSR_SEL_CFG, 64'h0, 1'b0);
		chk(o_msr_rdata, m_cfg);
		addr = {$urandom, $urandom} | 64'h40;
		load(addr);
		set_mask(1'b1);
		chk(o_cb_addr, 64'h0);
		load(addr);
		query(LEAF_APP_CAPS);
		chk({32'h0, o_query_data}, {32'h0, m_cfg[31:1] & 31'h7000_003f,
			m_usable});
		msr(1'b1, MSR_SEL_CBADDR, 64'h0, 1'b0);
		m_cb = 64'h0;
		chk(o_cb_addr, m_cb);
		chk({63'h0, o_profiler_active}, 64'h0);
		load(addr ^ 64'h80);
		set_mask(1'b0);
		chk(o_cb_addr, 64'h0);
		end_sim();
	end
endmodule : pucr_top_tb
